// ==== include/dbg_mask_pkg.sv ====
// Package of constants and types for the debug reset and interrupt masking block
package dbg_mask_pkg;
   // Execution states of the core as seen by the debug logic
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_BREAK = 3'b001,
      ST_STEP = 3'b010,
      ST_SRC_STEP = 3'b011,
      ST_RESET = 3'b100
   } exec_state_e;

   // Debug interface selection field encodings
   localparam logic [1:0] IF_SEL_FOUR_PIN = 2'b01;
   localparam logic [1:0] IF_SEL_ONE_PIN = 2'b10;
   localparam logic [1:0] IF_SEL_JTAG = 2'b11;

   // Number of pending interrupt sources: maskable, fast, floating point
   localparam int IRQ_SOURCES = 3;
   localparam int IRQ_MASKABLE = 0;
   localparam int IRQ_FAST = 1;
   localparam int IRQ_FPU = 2;

   // Cycles the core reset is held after a debugger reset
   localparam logic [3:0] CPU_RESET_CYCLES = 4'h4;
   localparam logic [3:0] COUNT_ZERO = 4'h0;
   localparam logic [3:0] COUNT_ONE = 4'h1;

   // Reset value of the debug master permission bit
   localparam logic DEBUG_PERMIT_RESET = 1'b1;
endpackage : dbg_mask_pkg

// ==== include/irq_hold_if.sv ====
// Interface carrying interrupt requests, mask and pending state to the hold unit
`timescale 1ns/1ps
`default_nettype none
interface irq_hold_if #(parameter int N = 3);
   logic [N-1:0] req;
   logic mask;
   logic [N-1:0] ack;
   logic [N-1:0] pending;
   logic [N-1:0] deliver;
   modport ctrl (output req, output mask, output ack, input pending, input deliver);
   modport hold (input req, input mask, input ack, output pending, output deliver);
endinterface : irq_hold_if
`default_nettype wire

// ==== core/irq_hold.sv ====
// Per-source interrupt hold: keeps masked requests pending and releases them later
`timescale 1ns/1ps
`default_nettype none
module irq_hold #(
   parameter int N = 3
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Request, mask and delivery
   irq_hold_if.hold port
);
   import dbg_mask_pkg::*;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_src
         // Set wins over acknowledge
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               port.pending[i] <= 1'b0;
            end else if (port.req[i]) begin
               port.pending[i] <= 1'b1; // (R9)
            end else if (port.ack[i] && !port.mask) begin
               port.pending[i] <= 1'b0;
            end
         end
         // Delivered only while the mask is off
         assign port.deliver[i] = port.pending[i] && !port.mask; // (R7) (R8) (R9)
      end
   endgenerate
endmodule : irq_hold
`default_nettype wire

// ==== core/dbg_mask_ctrl.sv ====
// Debug state control: masks resets and interrupts, replays them, forces breaks
// Behaviour
// (R1) Resets from user system or program are blocked during single stepping.
// (R2) Running passes resets; in break the debugger's reset mask choice applies.
// (R3) A debugger reset always resets the CPU, regardless of the mask.
// (R4) After a debugger reset every CPU enters break.
// (R5) Resets raised while masked are remembered and applied once unmasked.
// (R6) Target drives a pin reset only while the program runs.
// (R7) Interrupt acceptance is suppressed during break and single stepping.
// (R8) While running, interrupts follow the user system configuration only.
// (R9) Masked external, fast and FPU interrupts stay pending, served after unmask.
// (R10) Entering break takes the core out of halt mode.
// (R11) Stepping a halt instruction skips halt and breaks on the next instruction.
// (R12) Target releases its reset while the emulator connects.
// (R13) On connection the core starts from the reset vector before the link works.
// (R14) Program waits 120, 22 or 70 ms after reset before running.
// (R15) With the adapter board only the four-pin link is offered; code still picks JTAG if link_jtag is set while not connected.
// (R16) Software keeps the debug master permission bit at one.
// (R17) Interface field reads 01 four-pin, 10 one-pin, 11 JTAG.
`timescale 1ns/1ps
`default_nettype none
module dbg_mask_ctrl #(
   parameter int CPUS = 2,
   parameter logic [3:0] RESET_HOLD = dbg_mask_pkg::CPU_RESET_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Debugger commands as one-cycle pulses, plus the break and source step mask levels
   input wire logic dbg_break_req,
   input wire logic dbg_run_req,
   input wire logic dbg_step_req,
   input wire logic dbg_src_step_req,
   input wire logic dbg_reset_req,
   input wire logic break_reset_mask,
   input wire logic src_step_mask,
   // Link configuration
   input wire logic link_connected,
   input wire logic link_one_pin,
   input wire logic link_jtag,
   input wire logic adapter_board,
   // Core status and events
   input wire logic step_done,
   input wire logic halt_executed,
   input wire logic user_reset_req,
   input wire logic pin_reset_n,
   input wire logic [dbg_mask_pkg::IRQ_SOURCES-1:0] irq_req,
   input wire logic [dbg_mask_pkg::IRQ_SOURCES-1:0] irq_ack,
   // Guard permission write
   input wire logic permit_wr,
   input wire logic permit_wdata,
   // Outputs to the core
   output logic cpu_reset,
   output logic [CPUS-1:0] cpu_break,
   output logic halt_wake,
   output logic halt_block,
   output logic [dbg_mask_pkg::IRQ_SOURCES-1:0] irq_deliver,
   output logic [dbg_mask_pkg::IRQ_SOURCES-1:0] irq_pending,
   // Status
   output var dbg_mask_pkg::exec_state_e exec_state,
   output logic reset_pending,
   output logic reset_masked,
   output logic irq_masked,
   output logic debug_if_select_high,
   output logic debug_if_select_low,
   output logic four_pin_only,
   output logic debug_master_access_permit
);
   import dbg_mask_pkg::*;

   exec_state_e next_state;
   logic pin_sync1;
   logic pin_sync2;
   logic pin_reset_event;
   logic user_reset_event;
   logic [3:0] reset_count;
   logic step_halt;
   logic [1:0] if_sel;

   irq_hold_if #(.N(IRQ_SOURCES)) irq_bus ();

   // External reset pin passes two flip-flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync1 <= 1'b1;
         pin_sync2 <= 1'b1;
      end else begin
         pin_sync1 <= pin_reset_n;
         pin_sync2 <= pin_sync1;
      end
   end

   // Pin reset only acts while running; target must keep it idle otherwise
   assign pin_reset_event = !pin_sync2 && (exec_state == ST_RUN); // (R6) (R12)
   assign user_reset_event = user_reset_req || pin_reset_event;

   // Reset mask per execution state
   always_comb begin
      case (exec_state)
         ST_STEP: reset_masked = 1'b1; // (R1)
         ST_BREAK: reset_masked = break_reset_mask; // (R2)
         ST_SRC_STEP: reset_masked = src_step_mask;
         ST_RUN: reset_masked = 1'b0; // (R2)
         default: reset_masked = 1'b0;
      endcase
   end

   // Interrupt mask per execution state
   always_comb begin
      case (exec_state)
         ST_BREAK: irq_masked = 1'b1; // (R7)
         ST_STEP: irq_masked = 1'b1; // (R7)
         ST_SRC_STEP: irq_masked = src_step_mask;
         ST_RUN: irq_masked = 1'b0; // (R8)
         default: irq_masked = 1'b1;
      endcase
   end

   // Pending reset: set wins over the replay clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_pending <= 1'b0;
      end else if (user_reset_event && reset_masked) begin
         reset_pending <= 1'b1; // (R5)
      end else if (!reset_masked && exec_state != ST_RESET) begin
         reset_pending <= 1'b0; // (R5)
      end
   end

   // Halt instruction stepped: break on the next instruction instead of halting
   assign step_halt = (exec_state == ST_STEP) && halt_executed;
   assign halt_block = exec_state == ST_STEP; // (R11)

   // Execution state sequencing
   always_comb begin
      next_state = exec_state;
      case (exec_state)
         ST_RESET: begin
            if (reset_count == COUNT_ONE) begin
               next_state = ST_BREAK; // (R4)
            end
         end
         ST_RUN: begin
            if (dbg_break_req) begin
               next_state = ST_BREAK;
            end
         end
         ST_BREAK: begin
            if (dbg_run_req) begin
               next_state = ST_RUN;
            end else if (dbg_step_req) begin
               next_state = ST_STEP;
            end else if (dbg_src_step_req) begin
               next_state = ST_SRC_STEP;
            end
         end
         ST_STEP: begin
            if (step_done || step_halt || dbg_break_req) begin
               next_state = ST_BREAK; // (R11)
            end
         end
         ST_SRC_STEP: begin
            if (step_done || dbg_break_req) begin
               next_state = ST_BREAK;
            end
         end
         default: next_state = ST_BREAK;
      endcase
      if (dbg_reset_req) begin
         next_state = ST_RESET; // (R3)
      end
   end

   // Core starts out running from the reset vector before the link is ready
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         exec_state <= ST_RUN; // (R13)
      end else begin
         exec_state <= next_state;
      end
   end

   // Debugger reset hold counter
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_count <= COUNT_ZERO;
      end else if (dbg_reset_req) begin
         reset_count <= RESET_HOLD; // (R3)
      end else if (reset_count != COUNT_ZERO) begin
         reset_count <= reset_count - COUNT_ONE;
      end
   end

   // CPU reset: debugger reset, unmasked user reset or replayed pending reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_reset <= 1'b0;
      end else begin
         cpu_reset <= dbg_reset_req || (reset_count > COUNT_ONE)
            || (user_reset_event && !reset_masked) // (R2) (R3)
            || (reset_pending && !reset_masked); // (R5)
      end
   end

   // Break to every CPU, and wake from halt on break entry
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_break <= '0;
         halt_wake <= 1'b0;
      end else begin
         cpu_break <= {CPUS{next_state == ST_BREAK}}; // (R4)
         halt_wake <= (next_state == ST_BREAK) && (exec_state != ST_BREAK); // (R10)
      end
   end

   // Interrupt pending and release
   assign irq_bus.req = irq_req;
   assign irq_bus.mask = irq_masked;
   assign irq_bus.ack = irq_ack;

   irq_hold #(.N(IRQ_SOURCES)) u_irq_hold (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .port(irq_bus.hold)
   );

   assign irq_deliver = irq_bus.deliver; // (R9)
   assign irq_pending = irq_bus.pending;

   // Interface selection field; adapter board forces four-pin link unless JTAG is selected while not connected
   always_comb begin
      if (!link_connected && link_jtag) begin
         if_sel = IF_SEL_JTAG; // (R17)
      end else if (link_one_pin && !adapter_board) begin
         if_sel = IF_SEL_ONE_PIN; // (R17)
      end else begin
         if_sel = IF_SEL_FOUR_PIN; // (R15) (R17)
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         debug_if_select_high <= 1'b0;
         debug_if_select_low <= 1'b0;
         four_pin_only <= 1'b0;
      end else begin
         debug_if_select_high <= if_sel[1];
         debug_if_select_low <= if_sel[0];
         four_pin_only <= adapter_board; // (R15)
      end
   end

   // Guard permission bit, initial value one
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         debug_master_access_permit <= DEBUG_PERMIT_RESET; // (R16)
      end else if (permit_wr) begin
         debug_master_access_permit <= permit_wdata;
      end
   end
endmodule : dbg_mask_ctrl
`default_nettype wire

// ==== verif/dbg_mask_monitor.sv ====
// Assertion checker for the debug masking block
`timescale 1ns/1ps
`default_nettype none
module dbg_mask_monitor #(
   parameter int CPUS = 2
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Inputs
   input wire logic dbg_reset_req,
   input wire logic dbg_run_req,
   input wire logic dbg_break_req,
   input wire logic step_done,
   input wire logic halt_executed,
   input wire logic user_reset_req,
   input wire logic [dbg_mask_pkg::IRQ_SOURCES-1:0] irq_req,
   input wire logic adapter_board,
   // Outputs
   input wire logic cpu_reset,
   input wire logic [CPUS-1:0] cpu_break,
   input wire logic halt_wake,
   input wire logic halt_block,
   input wire logic [dbg_mask_pkg::IRQ_SOURCES-1:0] irq_deliver,
   input wire logic [dbg_mask_pkg::IRQ_SOURCES-1:0] irq_pending,
   input wire dbg_mask_pkg::exec_state_e exec_state,
   input wire logic reset_pending,
   input wire logic irq_masked,
   input wire logic four_pin_only,
   input wire logic debug_if_select_high,
   input wire logic debug_if_select_low
);
   import dbg_mask_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_dbg_reset_cpu: assert property (dbg_reset_req |=> cpu_reset)
      else $error("no cpu reset after debugger reset");
   chk_reset_break_all: assert property (
      dbg_reset_req |-> ##5 (exec_state == ST_BREAK && cpu_break == '1))
      else $error("not all cpus in break after debugger reset");
   chk_step_hold_reset: assert property (
      exec_state == ST_STEP && user_reset_req && !step_done
      && !(dbg_reset_req || dbg_run_req || dbg_break_req) |=> reset_pending && !cpu_reset)
      else $error("user reset not held during step");
   chk_run_reset_pass: assert property (
      exec_state == ST_RUN && user_reset_req |=> cpu_reset)
      else $error("user reset blocked while running");
   chk_break_irq_mask: assert property (
      exec_state inside {ST_BREAK, ST_STEP} |-> irq_masked && irq_deliver == 3'h0)
      else $error("interrupt open in break or step");
   chk_run_irq_free: assert property (
      exec_state == ST_RUN |-> !irq_masked && irq_deliver == irq_pending)
      else $error("interrupt masked while running");
   chk_irq_kept: assert property (
      irq_masked && |irq_req |=> (irq_pending & $past(irq_req)) == $past(irq_req))
      else $error("masked interrupt lost");
   chk_break_wake: assert property ($rose(exec_state == ST_BREAK) |-> halt_wake)
      else $error("no halt wake on break entry");
   chk_step_no_halt: assert property (
      exec_state == ST_STEP && halt_executed && !dbg_reset_req
      |-> halt_block ##1 (exec_state == ST_BREAK && !halt_block))
      else $error("stepped halt did not break on next instruction");
   chk_adapter_four_pin: assert property (
      adapter_board [*2] |-> four_pin_only
      && {debug_if_select_high, debug_if_select_low} == 2'h1)
      else $error("adapter board not four pin");
endmodule : dbg_mask_monitor
`default_nettype wire

// ==== verif/emu_model.sv ====
// Emulator model: issues debugger commands as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module emu_model (
   // Clock
   input wire logic core_clk,
   // Debugger commands
   output logic dbg_break_req,
   output logic dbg_run_req,
   output logic dbg_step_req,
   output logic dbg_src_step_req,
   output logic dbg_reset_req
);
   logic [4:0] cmd = 5'h00;
   assign {dbg_reset_req, dbg_src_step_req, dbg_step_req, dbg_run_req, dbg_break_req} = cmd;
   // Command 4 is the debugger reset, sent whatever the mask state
   task automatic send(input int c);
      @(posedge core_clk);
      cmd <= 5'h01 << c;
      @(posedge core_clk);
      cmd <= 5'h00;
      #1;
   endtask : send
endmodule : emu_model
`default_nettype wire

// ==== verif/tb.sv ====
// Testbench for the debug masking block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dbg_mask_pkg::*;
   logic core_clk, rst_n, dbg_break_req, dbg_run_req, dbg_step_req, dbg_src_step_req;
   logic dbg_reset_req, break_reset_mask, src_step_mask, link_connected, link_one_pin;
   logic link_jtag, adapter_board, step_done, halt_executed, user_reset_req, pin_reset_n;
   logic permit_wr, permit_wdata, cpu_reset, halt_wake, halt_block, reset_pending;
   logic reset_masked, irq_masked, debug_if_select_high, debug_if_select_low;
   logic four_pin_only, debug_master_access_permit;
   logic [1:0] cpu_break;
   logic [IRQ_SOURCES-1:0] irq_req, irq_ack, irq_deliver, irq_pending;
   exec_state_e exec_state;
   logic [3:0] cfg [4] = '{4'h8, 4'hC, 4'h2, 4'hD};
   logic [2:0] exp_if [4] = '{3'h2, 3'h4, 3'h6, 3'h3};
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   int k;
   dbg_mask_ctrl dut (.*);
   emu_model emu (.*);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   // One-cycle core events
   task automatic ev(input logic [2:0] rq, input logic [2:0] ak, input logic ur);
      @(posedge core_clk);
      irq_req <= rq;
      irq_ack <= ak;
      user_reset_req <= ur;
      halt_executed <= ak[0];
      @(posedge core_clk);
      irq_req <= 3'h0;
      irq_ack <= 3'h0;
      user_reset_req <= 1'b0;
      halt_executed <= 1'b0;
      #1;
   endtask : ev
   task automatic wait_reset(input int lim);
      k = 0;
      while (cpu_reset !== 1'b1 && k < lim) begin
         tick(1);
         k++;
      end
      cmp(cpu_reset, 1'b1);
      tick(6);
   endtask : wait_reset
   initial begin
      {rst_n, break_reset_mask, src_step_mask, link_connected, link_one_pin} = 5'h08;
      {link_jtag, adapter_board, step_done, halt_executed, user_reset_req} = 5'h00;
      {pin_reset_n, permit_wr, permit_wdata, irq_req, irq_ack} = 9'h140;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      permit_wr <= 1'b1;
      @(posedge core_clk);
      permit_wr <= 1'b0;
      tick(1);
      cmp({exec_state, debug_master_access_permit}, {ST_RUN, 1'b1});
      emu.send(4);
      cmp(cpu_reset, 1'b1);
      tick(4);
      cmp({exec_state, cpu_break, halt_wake}, {ST_BREAK, 2'h3, 1'b1});
      ev(3'h7, 3'h0, 1'b1);
      cmp({irq_pending, irq_deliver, reset_pending, cpu_reset}, 8'hE2);
      emu.send(1);
      cmp({exec_state, irq_deliver}, {ST_RUN, 3'h7});
      wait_reset(4);
      ev(3'h0, 3'h7, 1'b0);
      cmp(irq_pending, 3'h0);
      ev(3'h0, 3'h0, 1'b1);
      cmp(cpu_reset, 1'b1);
      tick(6);
      @(posedge core_clk);
      pin_reset_n <= 1'b0;
      wait_reset(6);
      @(posedge core_clk);
      pin_reset_n <= 1'b1;
      tick(3);
      emu.send(0);
      emu.send(2);
      cmp({exec_state, halt_block}, {ST_STEP, 1'b1});
      ev(3'h1, 3'h1, 1'b1);
      cmp({reset_pending, cpu_reset, halt_wake, irq_deliver}, 8'h28);
      emu.send(0);
      cmp({exec_state, halt_block}, {ST_BREAK, 1'b0});
      @(posedge core_clk);
      break_reset_mask <= 1'b0;
      wait_reset(4);
      @(posedge core_clk);
      src_step_mask <= 1'b1;
      emu.send(3);
      cmp({exec_state, irq_masked}, {ST_SRC_STEP, 1'b1});
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         {link_connected, link_one_pin, link_jtag, adapter_board} <= cfg[i];
         tick(2);
         cmp({debug_if_select_high, debug_if_select_low, four_pin_only}, exp_if[i]);
      end
      wrap_up();
   end
endmodule : tb
bind dbg_mask_ctrl dbg_mask_monitor #(.CPUS(CPUS)) mon (.*);
`default_nettype wire
